// ---- src/mmcp_pkg.sv ----
package mmcp_pkg;

	// Core clock and bus geometry
	localparam int CLK_PERIOD_PS = 10000;
	localparam int AXI_AW = 11;
	localparam int AXI_DW = 32;

	// Build-option vector widths
	localparam int TXCFG_W = 80;
	localparam int TXCFG_PFC_W = 368;
	localparam int RXCFG_W = 80;
	localparam int RXCFG_PFC_W = 96;
	localparam int STATUS_W = 2;
	localparam int TXSTAT_W = 26;
	localparam int TXSTAT_PFC_W = 27;
	localparam int RXSTAT_W = 30;
	localparam int RXSTAT_PFC_W = 31;

	// Management word offsets
	localparam logic [10:0] ADDR_TX_CFG = 11'h400;
	localparam logic [10:0] ADDR_RX_CFG = 11'h404;
	localparam logic [10:0] ADDR_MDIO_CFG = 11'h500;
	localparam logic [10:0] ADDR_MDIO_CMD = 11'h504;
	localparam logic [10:0] ADDR_MDIO_RD = 11'h508;
	localparam logic [10:0] ADDR_STATUS = 11'h600;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Reset values and field positions
	localparam logic [31:0] TX_CFG_RST = 32'h0000_0002;
	localparam logic [31:0] RX_CFG_RST = 32'h0000_0002;
	localparam logic [31:0] MDIO_CFG_RST = 32'h0000_0053;
	localparam int TXCFG_EN_BIT = 1;
	localparam int RXCFG_EN_BIT = 1;
	localparam int MDIO_EN_BIT = 6;
	localparam int MDIO_DIV_LSB = 0;
	localparam int MDIO_DIV_W = 6;
	localparam int MDIO_BUSY_BIT = 16;

	// Management frame layout
	localparam logic [5:0] MDIO_LAST_BIT = 6'h3f;
	localparam logic [5:0] MDIO_TA_BIT = 6'h2e;
	localparam logic [5:0] MDIO_DATA_BIT = 6'h30;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;

	// Timing figures and derived cycle counts
	localparam int RX_GAP_NS = 100;
	localparam int RX_GAP_CYC = (RX_GAP_NS * 1000) / CLK_PERIOD_PS;
	localparam int TX_SETTLE_NS = 200;
	localparam int TX_SETTLE_CYC =
		(TX_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RX_LOCK_EDGES = 8;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] regad;
		logic [15:0] data;
	} mmcp_mdio_cmd_t;

	typedef enum logic [2:0] {
		MD_IDLE = 3'b001,
		MD_SHIFT = 3'b010,
		MD_DONE = 3'b100
	} mmcp_mdio_st_t;

endpackage

// ---- src/mmcp_stat_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmcp_stat_capture
	import mmcp_pkg::*;
#(
	parameter int W = 26
) (
	input wire logic clock, // Core clock
	input wire logic rst, // Synchronised core reset
	input wire logic enable, // Side enabled by configuration
	input wire logic frame_done, // One pulse per finished frame
	input wire logic [W-1:0] flags, // Per-frame flags from datapath
	output logic [W-1:0] vec_ff, // Captured flag word
	output logic valid_ff // One-cycle valid strobe
);

	wire take = frame_done && enable;

	// Word is loaded together with the strobe and then held
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vec_ff <= '0;
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= take;
			if (take) begin
				vec_ff <= flags;
			end
		end
	end

endmodule
`default_nettype wire

// ---- src/mmcp_top.sv ----
// How it works
// - An AXI4-Lite slave, 32-bit data, 11-bit address.
// - Reset high resets the core asynchronously.
// - Without the port, config vectors and status serve.
// - Flow control widens the config vectors.
// - Config bits are acted on as they stand.
// - Core drives mdc and MDIO; tri high releases the line.
// - Each sent frame yields a flag word and strobe.
// - Each received frame yields a flag word and strobe while rx clock is locked.
// - A tx clock and a 90 degree lagging copy are output.
// - A tx clock goes to the PHY; its rx clock comes in.
// - Rx logic runs on the core clock and outputs a PHY-derived clock.
// - A lock output shows rx clock alignment.
`timescale 1ns/1ps
`default_nettype none
module mmcp_top
	import mmcp_pkg::*;
#(
	parameter bit MGMT_PRESENT = 1'b1,
	parameter bit PFC_EN = 1'b0,
	localparam int TXC_W = PFC_EN ? TXCFG_PFC_W : TXCFG_W,
	localparam int RXC_W = PFC_EN ? RXCFG_PFC_W : RXCFG_W,
	localparam int TXS_W = PFC_EN ? TXSTAT_PFC_W : TXSTAT_W,
	localparam int RXS_W = PFC_EN ? RXSTAT_PFC_W : RXSTAT_W
) (
	input wire logic clock, // Core and management clock
	input wire logic rst, // Core reset, active high
	input wire logic s_axi_aresetn, // Management reset, active low
	input wire logic [AXI_AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address accept
	input wire logic [AXI_DW-1:0] s_axi_wdata, // Write data
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data accept
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response accept
	input wire logic [AXI_AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address accept
	output logic [AXI_DW-1:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data accept
	input wire logic [TXC_W-1:0] tx_cfg_vec_in, // Tx config vector
	input wire logic [RXC_W-1:0] rx_cfg_vec_in, // Rx config vector
	output logic [STATUS_W-1:0] status_vec, // Core status
	output logic mdc, // MDIO clock
	input wire logic mdio_in, // MDIO pin input
	output logic mdio_out, // MDIO pin output
	output logic mdio_tri, // High releases MDIO line
	input wire logic tx_frame_done, // Tx frame finished pulse
	input wire logic [TXS_W-1:0] tx_frame_flags, // Tx frame flags
	output logic [TXS_W-1:0] tx_stat_vec, // Tx statistics word
	output logic tx_stat_valid, // Tx statistics strobe
	input wire logic rx_frame_done, // Rx frame finished pulse
	input wire logic [RXS_W-1:0] rx_frame_flags, // Rx frame flags
	output logic [RXS_W-1:0] rx_stat_vec, // Rx statistics word
	output logic rx_stat_valid, // Rx statistics strobe
	output logic tx_system_clock, // Derived tx clock
	output logic tx_quadrature_clock, // Tx clock shifted 90 degrees
	output logic tx_clock_locked, // Tx clocking settled
	output logic phy_tx_clock, // Forwarded clock to PHY
	input wire logic phy_rx_clock, // Receive clock from PHY
	output logic rx_system_clock, // Derived rx clock
	output logic rx_clock_locked // Rx clock alignment achieved
);

	// Reset release synchroniser; assertion stays asynchronous
	logic rst_meta_ff, core_rst_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rst_meta_ff <= 1'b1;
			core_rst_ff <= 1'b1;
		end else begin
			rst_meta_ff <= 1'b0;
			core_rst_ff <= rst_meta_ff;
		end
	end
	wire core_rst = core_rst_ff;
	wire axi_rst = !s_axi_aresetn;

	// Management slave state
	logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff, txcfg_ff, rxcfg_ff, mdcfg_ff;
	logic mdio_busy_ff;
	logic [15:0] mdio_rd_ff;
	logic [STATUS_W-1:0] status_ff;

	// Handshake qualifiers
	wire aw_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff && !awready_ff;
	wire wr_fire = awready_ff && s_axi_awvalid && s_axi_wvalid;
	wire ar_go = s_axi_arvalid && !arready_ff && !rvalid_ff;
	wire rd_fire = arready_ff && s_axi_arvalid;

	// Write decode
	wire wr_txcfg = s_axi_awaddr == ADDR_TX_CFG;
	wire wr_rxcfg = s_axi_awaddr == ADDR_RX_CFG;
	wire wr_mdcfg = s_axi_awaddr == ADDR_MDIO_CFG;
	wire wr_mdcmd = s_axi_awaddr == ADDR_MDIO_CMD;
	wire wr_ok = wr_txcfg || wr_rxcfg || wr_mdcfg ||
		(wr_mdcmd && !mdio_busy_ff);
	wire mdio_start = wr_fire && wr_mdcmd && !mdio_busy_ff;

	// Read decode; unmapped and write-only addresses answer SLVERR
	wire rd_hit = s_axi_araddr == ADDR_TX_CFG ||
		s_axi_araddr == ADDR_RX_CFG || s_axi_araddr == ADDR_MDIO_CFG ||
		s_axi_araddr == ADDR_MDIO_RD || s_axi_araddr == ADDR_STATUS;
	wire [31:0] rd_mux =
		(s_axi_araddr == ADDR_TX_CFG) ? txcfg_ff :
		(s_axi_araddr == ADDR_RX_CFG) ? rxcfg_ff :
		(s_axi_araddr == ADDR_MDIO_CFG) ? mdcfg_ff :
		(s_axi_araddr == ADDR_MDIO_RD) ?
			{15'h0000, mdio_busy_ff, mdio_rd_ff} :
		(s_axi_araddr == ADDR_STATUS) ?
			{30'h0000_0000, status_ff} : 32'h0000_0000;

	// Write channel
	always_ff @(posedge clock or posedge axi_rst) begin
		if (axi_rst) begin
			awready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else begin
			awready_ff <= aw_go;
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Host-written config words
	always_ff @(posedge clock or posedge axi_rst) begin
		if (axi_rst) begin
			txcfg_ff <= TX_CFG_RST;
			rxcfg_ff <= RX_CFG_RST;
			mdcfg_ff <= MDIO_CFG_RST;
		end else if (wr_fire) begin
			if (wr_txcfg) txcfg_ff <= s_axi_wdata;
			if (wr_rxcfg) rxcfg_ff <= s_axi_wdata;
			if (wr_mdcfg) mdcfg_ff <= s_axi_wdata;
		end
	end

	// Read channel
	always_ff @(posedge clock or posedge axi_rst) begin
		if (axi_rst) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else begin
			arready_ff <= ar_go;
			if (rd_fire) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_mux;
				rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Live config source, used as it stands
	wire [31:0] tx_cfg = MGMT_PRESENT ? txcfg_ff : tx_cfg_vec_in[31:0];
	wire [31:0] rx_cfg = MGMT_PRESENT ? rxcfg_ff : rx_cfg_vec_in[31:0];
	wire [31:0] md_cfg = MGMT_PRESENT ? mdcfg_ff : MDIO_CFG_RST;
	wire tx_en = tx_cfg[TXCFG_EN_BIT];
	wire rx_en = rx_cfg[RXCFG_EN_BIT];
	wire md_en = md_cfg[MDIO_EN_BIT];
	wire [MDIO_DIV_W-1:0] md_div = md_cfg[MDIO_DIV_LSB +: MDIO_DIV_W];

	// MDIO clock divider; mdc stops low while disabled
	logic [MDIO_DIV_W-1:0] mdc_cnt_ff;
	logic mdc_ff;
	wire mdc_tick = md_en && (mdc_cnt_ff >= md_div);
	wire mdc_rise = mdc_tick && !mdc_ff;
	wire mdc_fall = mdc_tick && mdc_ff;
	always_ff @(posedge clock or posedge core_rst) begin
		if (core_rst) begin
			mdc_cnt_ff <= '0;
			mdc_ff <= 1'b0;
		end else if (!md_en) begin
			mdc_cnt_ff <= '0;
			mdc_ff <= 1'b0;
		end else begin
			mdc_cnt_ff <= mdc_tick ? '0 : mdc_cnt_ff + 1'b1;
			if (mdc_tick) mdc_ff <= !mdc_ff;
		end
	end

	// MDIO input synchroniser
	logic mdi_s1_ff, mdi_s2_ff;
	always_ff @(posedge clock or posedge core_rst) begin
		if (core_rst) begin
			mdi_s1_ff <= 1'b1;
			mdi_s2_ff <= 1'b1;
		end else begin
			mdi_s1_ff <= mdio_in;
			mdi_s2_ff <= mdi_s1_ff;
		end
	end

	// Management frame: 32 preamble ones, then start, op, addresses, data
	mmcp_mdio_st_t md_st_ff, nxt_md_st;
	mmcp_mdio_cmd_t cmd_ff;
	logic [5:0] bit_ff;
	logic mdo_ff, mdt_ff;
	wire [31:0] frame = {2'b01, cmd_ff.op, cmd_ff.phy, cmd_ff.regad,
		2'b10, cmd_ff.data};
	wire is_read = cmd_ff.op == OP_READ;
	wire in_pre = !bit_ff[5];
	wire nxt_mdo = in_pre ? 1'b1 : frame[5'd31 - bit_ff[4:0]];
	wire nxt_rel = is_read && (bit_ff >= MDIO_TA_BIT);
	wire last_bit = bit_ff == MDIO_LAST_BIT;
	wire launched = !mdt_ff || nxt_rel; // No rise before bit 0 is out

	// Next state of the frame engine
	always_comb begin
		nxt_md_st = md_st_ff;
		case (md_st_ff)
			MD_IDLE: if (mdio_start) nxt_md_st = MD_SHIFT;
			MD_SHIFT: if (mdc_rise && last_bit) nxt_md_st = MD_DONE;
			MD_DONE: if (mdc_fall) nxt_md_st = MD_IDLE;
			default: nxt_md_st = MD_IDLE;
		endcase
	end

	// Drive on mdc fall, sample and advance on mdc rise
	always_ff @(posedge clock or posedge core_rst) begin
		if (core_rst) begin
			md_st_ff <= MD_IDLE;
			cmd_ff <= '0;
			bit_ff <= '0;
			mdo_ff <= 1'b1;
			mdt_ff <= 1'b1;
			mdio_busy_ff <= 1'b0;
			mdio_rd_ff <= 16'h0000;
		end else begin
			md_st_ff <= nxt_md_st;
			if (mdio_start) begin
				cmd_ff <= mmcp_mdio_cmd_t'(s_axi_wdata[27:0]);
				bit_ff <= '0;
				mdio_busy_ff <= 1'b1;
			end
			if (md_st_ff == MD_SHIFT && mdc_fall) begin
				mdo_ff <= nxt_mdo;
				mdt_ff <= nxt_rel;
			end
			if (md_st_ff == MD_SHIFT && mdc_rise && launched) begin
				bit_ff <= bit_ff + 1'b1;
				if (is_read && bit_ff >= MDIO_DATA_BIT)
					mdio_rd_ff <= {mdio_rd_ff[14:0], mdi_s2_ff};
			end
			if (md_st_ff == MD_DONE && mdc_fall) begin
				mdt_ff <= 1'b1; // Release line between frames
				mdio_busy_ff <= 1'b0;
			end
		end
	end

	// Transmit clocks: divide by four, quadrature is one quarter behind
	logic [1:0] txph_ff;
	logic txc0_ff, txc90_ff, phytx_ff, txlock_ff;
	logic [7:0] settle_ff;
	wire [1:0] nxt_txph = txph_ff + 2'h1;
	always_ff @(posedge clock or posedge core_rst) begin
		if (core_rst) begin
			txph_ff <= 2'h0;
			txc0_ff <= 1'b0;
			txc90_ff <= 1'b0;
			phytx_ff <= 1'b0;
			settle_ff <= 8'h00;
			txlock_ff <= 1'b0;
		end else begin
			txph_ff <= nxt_txph;
			txc0_ff <= nxt_txph[1];
			txc90_ff <= txc0_ff;
			// Forwarded clock from its own flop, same value as the tx clock
			phytx_ff <= nxt_txph[1] ? 1'b1 : 1'b0;
			if (settle_ff != 8'(TX_SETTLE_CYC))
				settle_ff <= settle_ff + 8'h01;
			txlock_ff <= settle_ff == 8'(TX_SETTLE_CYC);
		end
	end

	// PHY rx clock: sync, edge and lock tracking
	logic rxc_s1_ff, rxc_s2_ff, rxc_s3_ff, rxclk_ff, rxlock_ff;
	logic [7:0] gap_ff;
	logic [3:0] edges_ff;
	wire rx_edge = rxc_s2_ff && !rxc_s3_ff;
	wire gap_over = gap_ff >= 8'(RX_GAP_CYC);
	always_ff @(posedge clock or posedge core_rst) begin
		if (core_rst) begin
			rxc_s1_ff <= 1'b0;
			rxc_s2_ff <= 1'b0;
			rxc_s3_ff <= 1'b0;
			rxclk_ff <= 1'b0;
			gap_ff <= 8'h00;
			edges_ff <= 4'h0;
			rxlock_ff <= 1'b0;
		end else begin
			rxc_s1_ff <= phy_rx_clock;
			rxc_s2_ff <= rxc_s1_ff;
			rxc_s3_ff <= rxc_s2_ff;
			rxclk_ff <= rxc_s2_ff;
			if (rx_edge) begin
				gap_ff <= 8'h00;
				if (edges_ff != 4'(RX_LOCK_EDGES))
					edges_ff <= edges_ff + 4'h1;
			end else if (gap_over) begin
				edges_ff <= 4'h0;
			end else begin
				gap_ff <= gap_ff + 8'h01;
			end
			// Lock drops once no PHY clock edge is seen for RX_GAP_CYC cycles
			rxlock_ff <= !gap_over && edges_ff == 4'(RX_LOCK_EDGES);
		end
	end

	// Status word: rx lock above tx lock
	always_ff @(posedge clock or posedge core_rst) begin
		if (core_rst) begin
			status_ff <= '0;
		end else begin
			status_ff <= {rxlock_ff, txlock_ff};
		end
	end

	// Per-frame statistics
	mmcp_stat_capture #(.W(TXS_W)) u_tx_stat (
		.clock(clock),
		.rst(core_rst),
		.enable(tx_en),
		.frame_done(tx_frame_done),
		.flags(tx_frame_flags),
		.vec_ff(tx_stat_vec),
		.valid_ff(tx_stat_valid)
	);
	mmcp_stat_capture #(.W(RXS_W)) u_rx_stat (
		.clock(clock),
		.rst(core_rst),
		.enable(rx_en && rxlock_ff),
		.frame_done(rx_frame_done),
		.flags(rx_frame_flags),
		.vec_ff(rx_stat_vec),
		.valid_ff(rx_stat_valid)
	);

	// Outputs straight from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = awready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign status_vec = status_ff;
	assign mdc = mdc_ff;
	assign mdio_out = mdo_ff;
	assign mdio_tri = mdt_ff;
	assign tx_system_clock = txc0_ff;
	assign tx_quadrature_clock = txc90_ff;
	assign tx_clock_locked = txlock_ff;
	assign phy_tx_clock = phytx_ff;
	assign rx_system_clock = rxclk_ff;
	assign rx_clock_locked = rxlock_ff;

endmodule
`default_nettype wire

// ---- tb/mmcp_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmcp_top_assertions
	import mmcp_pkg::*;
#(
	parameter bit PFC_EN = 1'b0,
	localparam int TXS_W = PFC_EN ? TXSTAT_PFC_W : TXSTAT_W,
	localparam int RXS_W = PFC_EN ? RXSTAT_PFC_W : RXSTAT_W
) (
	input wire logic clock, // Clock
	input wire logic rst, // Core reset
	input wire logic s_axi_aresetn, // Bus reset
	input wire logic s_axi_awready, // Address accept
	input wire logic s_axi_wready, // Data accept
	input wire logic [1:0] s_axi_bresp, // Write code
	input wire logic s_axi_bvalid, // Write answer
	input wire logic s_axi_bready, // Answer taken
	input wire logic s_axi_arready, // Read accept
	input wire logic s_axi_rvalid, // Read answer
	input wire logic mdc, // Mgmt clock
	input wire logic mdio_tri, // Line release
	input wire logic tx_frame_done, // Tx end
	input wire logic [TXS_W-1:0] tx_frame_flags, // Tx flags
	input wire logic [TXS_W-1:0] tx_stat_vec, // Tx word
	input wire logic tx_stat_valid, // Tx strobe
	input wire logic rx_frame_done, // Rx end
	input wire logic [RXS_W-1:0] rx_frame_flags, // Rx flags
	input wire logic [RXS_W-1:0] rx_stat_vec, // Rx word
	input wire logic rx_stat_valid, // Rx strobe
	input wire logic tx_system_clock, // Tx clock
	input wire logic tx_quadrature_clock, // Tx 90 deg
	input wire logic tx_clock_locked, // Tx lock
	input wire logic phy_tx_clock, // Forwarded
	input wire logic phy_rx_clock, // From PHY
	input wire logic rx_system_clock, // Rx clock
	input wire logic rx_clock_locked, // Rx lock
	input wire logic [STATUS_W-1:0] status_vec // Status
);
	default clocking @(posedge clock);
	endclocking

	// Idle time of the PHY clock; saturates so it never wraps to look busy
	logic [3:0] quiet_ff;
	logic last_ff;
	wire logic moved = phy_rx_clock != last_ff;
	wire logic [3:0] nxt_quiet = moved ? 4'h0 : quiet_ff + 4'(quiet_ff != 4'hf);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			quiet_ff <= 4'h0;
			last_ff <= 1'b0;
		end else begin
			quiet_ff <= nxt_quiet;
			last_ff <= phy_rx_clock;
		end
	end

	// Write transfer steps
	sequence s_wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		s_axi_bvalid ##1 (s_axi_bvalid || $past(s_axi_bready));
	endsequence

	a_write_answer: assert property (disable iff (!s_axi_aresetn)
		s_wr_taken |=> s_wr_answer) else $error("b late");
	a_bresp_hold: assert property (disable iff (!s_axi_aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("b dropped");
	a_read_answer: assert property (disable iff (!s_axi_aresetn)
		s_axi_arready |=> s_axi_rvalid) else $error("r late");
	a_reset_quiet: assert property (
		rst |-> mdio_tri && !mdc && !tx_stat_valid && !rx_stat_valid
		&& !tx_clock_locked) else $error("reset busy");
	a_mdio_launch: assert property (disable iff (rst)
		$fell(mdio_tri) |-> !mdc) else $error("mdio launch");
	a_tx_stat_cause: assert property (disable iff (rst)
		tx_stat_valid |-> $past(tx_frame_done)
		&& tx_stat_vec == $past(tx_frame_flags)) else $error("tx word wrong");
	a_rx_stat_cause: assert property (disable iff (rst)
		rx_stat_valid |-> $past(rx_frame_done && rx_clock_locked)
		&& rx_stat_vec == $past(rx_frame_flags)) else $error("rx word wrong");
	a_stat_word_hold: assert property (disable iff (rst)
		!tx_stat_valid && !rx_stat_valid |-> $stable(tx_stat_vec)
		&& $stable(rx_stat_vec)) else $error("word moved");
	a_quad_lag: assert property (disable iff (rst)
		tx_clock_locked |-> tx_quadrature_clock == $past(tx_system_clock))
		else $error("quad lag");
	a_phy_fwd: assert property (disable iff (rst)
		phy_tx_clock == tx_system_clock) else $error("fwd clock");
	a_rx_delay: assert property (disable iff (rst)
		rx_clock_locked |-> rx_system_clock == $past(phy_rx_clock, 3))
		else $error("rx delay");
	a_rx_lock_loss: assert property (disable iff (rst)
		quiet_ff == 4'hf |-> !rx_clock_locked) else $error("lock kept");
	a_status_mirror: assert property (disable iff (rst)
		status_vec == $past({rx_clock_locked, tx_clock_locked}))
		else $error("status");
endmodule
`default_nettype wire

// ---- tb/mmcp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmcp_host
	import mmcp_pkg::*;
(
	input wire logic clock, // Clock
	output logic [AXI_AW-1:0] s_axi_awaddr, // Write address
	output logic s_axi_awvalid, // Address valid
	input wire logic s_axi_awready, // Address accept
	output logic [AXI_DW-1:0] s_axi_wdata, // Write data
	output logic s_axi_wvalid, // Data valid
	input wire logic s_axi_wready, // Data accept
	input wire logic [1:0] s_axi_bresp, // Write code
	input wire logic s_axi_bvalid, // Write answer
	output logic s_axi_bready, // Answer taken
	output logic [AXI_AW-1:0] s_axi_araddr, // Read address
	output logic s_axi_arvalid, // Read valid
	input wire logic s_axi_arready, // Read accept
	input wire logic [AXI_DW-1:0] s_axi_rdata, // Read data
	input wire logic [1:0] s_axi_rresp, // Read code
	input wire logic s_axi_rvalid, // Read answer
	output logic s_axi_rready // Read taken
);
	// Bus idle from time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// Request held until accept; released lines show inverted values
	task automatic wr(input logic [10:0] a, input logic [31:0] d,
			output logic [1:0] r);
		int n;
		@(negedge clock);
		s_axi_awaddr = a;
		s_axi_wdata = d;
		s_axi_awvalid = 1'b1;
		s_axi_wvalid = 1'b1;
		for (n = 0; n < 20 && s_axi_awready !== 1'b1; n++) @(negedge clock);
		@(negedge clock);
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_awaddr = ~a;
		s_axi_wdata = ~d;
		for (n = 0; n < 20 && s_axi_bvalid !== 1'b1; n++) @(negedge clock);
		r = s_axi_bresp;
		s_axi_bready = 1'b1;
		@(negedge clock);
		s_axi_bready = 1'b0;
	endtask

	task automatic rd(input logic [10:0] a, output logic [31:0] d,
			output logic [1:0] r);
		int n;
		@(negedge clock);
		s_axi_araddr = a;
		s_axi_arvalid = 1'b1;
		for (n = 0; n < 20 && s_axi_arready !== 1'b1; n++) @(negedge clock);
		@(negedge clock);
		s_axi_arvalid = 1'b0;
		s_axi_araddr = ~a;
		for (n = 0; n < 20 && s_axi_rvalid !== 1'b1; n++) @(negedge clock);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready = 1'b1;
		@(negedge clock);
		s_axi_rready = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/mmcp_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
bind mmcp_top mmcp_top_assertions #(.PFC_EN(PFC_EN)) chk (
	.clock, .rst, .s_axi_aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
	.s_axi_rvalid, .mdc, .mdio_tri, .tx_frame_done, .tx_frame_flags,
	.tx_stat_vec, .tx_stat_valid, .rx_frame_done, .rx_frame_flags,
	.rx_stat_vec, .rx_stat_valid, .tx_system_clock, .tx_quadrature_clock,
	.tx_clock_locked, .phy_tx_clock, .phy_rx_clock, .rx_system_clock,
	.rx_clock_locked, .status_vec
);
module mmcp_top_test
	import mmcp_pkg::*;
;
	logic clock, rst, s_axi_aresetn, s_axi_awvalid, s_axi_awready;
	logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [TXCFG_W-1:0] tx_cfg_vec_in;
	logic [RXCFG_W-1:0] rx_cfg_vec_in;
	logic [STATUS_W-1:0] status_vec;
	logic mdc, mdio_in, mdio_out, mdio_tri, rx_run;
	logic tx_frame_done, tx_stat_valid, rx_frame_done, rx_stat_valid;
	logic [TXSTAT_W-1:0] tx_frame_flags, tx_stat_vec, last_tx;
	logic [RXSTAT_W-1:0] rx_frame_flags, rx_stat_vec, last_rx;
	logic tx_system_clock, tx_quadrature_clock, tx_clock_locked;
	logic phy_tx_clock, phy_rx_clock, rx_system_clock, rx_clock_locked;
	logic [63:0] mdio_sh;
	logic [31:0] d;
	int fails, num_checks, ndrv;

	mmcp_top #(.MGMT_PRESENT(1'b1), .PFC_EN(1'b0)) uut (
		.clock, .rst, .s_axi_aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .tx_cfg_vec_in, .rx_cfg_vec_in,
		.status_vec, .mdc, .mdio_in, .mdio_out, .mdio_tri, .tx_frame_done,
		.tx_frame_flags, .tx_stat_vec, .tx_stat_valid, .rx_frame_done,
		.rx_frame_flags, .rx_stat_vec, .rx_stat_valid, .tx_system_clock,
		.tx_quadrature_clock, .tx_clock_locked, .phy_tx_clock,
		.phy_rx_clock, .rx_system_clock, .rx_clock_locked
	);
	mmcp_host host (
		.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);

	// Shared line with pull-up, so a released line reads high
	assign mdio_in = mdio_tri ? 1'b1 : mdio_out;

	// 100 MHz core and reference clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// PHY clock off the core grid so it never ties with an edge
	initial begin
		phy_rx_clock = 1'b0;
		#3.5;
		forever #17 if (rx_run) phy_rx_clock = ~phy_rx_clock;
	end

	// Collect driven MDIO bits on rising mdc
	always @(posedge mdc) begin
		if (mdio_tri === 1'b0) begin
			mdio_sh <= {mdio_sh[62:0], mdio_out};
			ndrv <= ndrv + 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic t_regs();
		host.rd(ADDR_TX_CFG, d, r);
		check(d, TX_CFG_RST);
		host.rd(ADDR_MDIO_CFG, d, r);
		check(d, MDIO_CFG_RST);
		host.wr(ADDR_STATUS, 32'h0000_0001, r);
		check(32'(r), 32'(RESP_SLVERR));
		host.rd(11'h7fc, d, r);
		check(d, 32'h0000_0000);
		check(32'(r), 32'(RESP_SLVERR));
		$display("Register test done");
	endtask

	// Two frames back to back, then two quiet cycles with flags moving
	task automatic frames(input bit tx_on, input bit rx_on,
			input logic [TXSTAT_W-1:0] ft, input logic [RXSTAT_W-1:0] fr);
		int i;
		for (i = 0; i < 4; i++) begin
			@(negedge clock);
			if (i > 0) begin
				check(32'({(tx_on && i < 3), last_tx}), 32'({tx_stat_valid, tx_stat_vec}));
				check(32'({(rx_on && i < 3), last_rx}), 32'({rx_stat_valid, rx_stat_vec}));
			end
			tx_frame_done = (i < 2);
			rx_frame_done = (i < 2);
			tx_frame_flags = ft ^ TXSTAT_W'(i);
			rx_frame_flags = fr ^ RXSTAT_W'(i);
			if (tx_on && i < 2) last_tx = tx_frame_flags;
			if (rx_on && i < 2) last_rx = rx_frame_flags;
		end
	endtask

	task automatic t_stats();
		rx_run = 1'b1;
		repeat (60) @(negedge clock);
		check(32'(rx_clock_locked), 32'd1);
		frames(1'b1, 1'b1, 26'h2aa_5555, 30'h1555_aaaa);
		host.wr(ADDR_TX_CFG, 32'h0000_0000, r);
		host.rd(ADDR_TX_CFG, d, r);
		check(d, 32'h0000_0000);
		rx_run = 1'b0;
		repeat (20) @(negedge clock);
		check(32'(rx_clock_locked), 32'd0);
		frames(1'b0, 1'b0, 26'h0f0_f0f0, 30'h0ff0_0ff0);
		host.wr(ADDR_TX_CFG, TX_CFG_RST, r);
		rx_run = 1'b1;
		$display("Statistics test done");
	endtask

	task automatic t_clocks();
		int i, rises;
		logic prev;
		rises = 0;
		prev = tx_system_clock;
		for (i = 0; i < 40; i++) begin
			@(negedge clock);
			rises += int'(tx_system_clock && !prev);
			check(32'(tx_quadrature_clock), 32'(prev));
			check(32'(phy_tx_clock), 32'(tx_system_clock));
			prev = tx_system_clock;
		end
		check(32'(rises), 32'd10);
		host.rd(ADDR_STATUS, d, r);
		check(d, 32'h0000_0003);
		$display("Clock test done");
	endtask

	task automatic wait_idle();
		int n;
		for (n = 0; n < 200; n++) begin
			host.rd(ADDR_MDIO_RD, d, r);
			if (d[MDIO_BUSY_BIT] === 1'b0) break;
		end
	endtask

	task automatic t_mdio();
		host.wr(ADDR_MDIO_CFG, 32'h0000_0041, r);
		ndrv = 0;
		host.wr(ADDR_MDIO_CMD, {4'h0, OP_WRITE, 5'h03, 5'h05, 16'ha5c3}, r);
		host.rd(ADDR_MDIO_RD, d, r);
		check(32'(d[MDIO_BUSY_BIT]), 32'd1);
		host.wr(ADDR_MDIO_CMD, 32'h0000_0000, r);
		check(32'(r), 32'(RESP_SLVERR));
		wait_idle();
		check(mdio_sh[63:32], 32'hffff_ffff);
		check(mdio_sh[31:0], {2'b01, OP_WRITE, 5'h03, 5'h05, 2'b10, 16'ha5c3});
		check(32'(ndrv), 32'd64);
		ndrv = 0;
		host.wr(ADDR_MDIO_CMD, {4'h0, OP_READ, 5'h01, 5'h02, 16'h0000}, r);
		wait_idle();
		check(32'(ndrv), 32'd46);
		check(d, 32'h0000_ffff);
		check(32'(mdio_tri), 32'd1);
		$display("MDIO test done");
	endtask

	task automatic t_reset();
		int n;
		@(negedge clock);
		rst = 1'b1;
		@(negedge clock);
		check(32'({mdc, mdio_tri, tx_clock_locked, tx_stat_valid}), 32'h4);
		rst = 1'b0;
		for (n = 0; n < 40 && tx_clock_locked !== 1'b1; n++) @(negedge clock);
		check(32'(n), 32'd23);
		host.rd(ADDR_MDIO_CFG, d, r);
		check(d, 32'h0000_0041);
		s_axi_aresetn = 1'b0;
		@(negedge clock);
		s_axi_aresetn = 1'b1;
		host.rd(ADDR_MDIO_CFG, d, r);
		check(d, MDIO_CFG_RST);
		$display("Reset test done");
	endtask

	// Main sequence
	initial begin
		{rst, s_axi_aresetn, rx_run, tx_frame_done, rx_frame_done} = 5'b10000;
		{tx_frame_flags, rx_frame_flags, last_tx, last_rx} = '0;
		{tx_cfg_vec_in, rx_cfg_vec_in, mdio_sh} = '0;
		{fails, num_checks, ndrv} = '0;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		s_axi_aresetn = 1'b1;
		repeat (30) @(negedge clock);
		t_regs();
		t_stats();
		t_clocks();
		t_mdio();
		t_reset();
		close_out();
	end

	// Watchdog, over twenty times the expected run
	initial begin
		#200000;
		fails++;
		close_out();
	end
endmodule
`default_nettype wire
